/* File: design/board_reset_pkg.sv */
/*
 * Shared types and constants for the board reset distribution block:
 * reset source and target groups, default processor map windows,
 * map region codes and reset values of the block's state.
 * Assumes one 100 MHz clock and a synchronous active-low block reset.
 */
`default_nettype none

package board_reset_pkg;

   // -----------------------------------------------------------------
   // Reset sources and targets
   // -----------------------------------------------------------------
   // One bit per reset source, all active high inside the block
   typedef struct packed {
      logic por;     // Power-on reset
      logic sw;      // Front-panel reset switch
      logic wdog;    // Timekeeper watchdog request
      logic hot;     // Alternate hot reset control
      logic pciisa;  // PCI/ISA I/O reset
      logic vmein;   // Incoming VMEbus system reset
      logic vsys;    // VME bridge system software reset
      logic vloc;    // VME bridge local software reset
   } src_t;

   // One bit per reset target, all active high
   typedef struct packed {
      logic proc;    // Processor
      logic hostbr;  // Host bridge
      logic memctl;  // Memory controller
      logic pci;     // PCI devices
      logic isa;     // ISA devices
      logic vme;     // VMEbus, only as system controller
   } tgt_t;

   // -----------------------------------------------------------------
   // Default processor map regions, one-hot
   // -----------------------------------------------------------------
   typedef enum logic [5:0] {
      REG_UNMAPPED = 6'h01,  // Hole in the default map
      REG_PCIISA_IO = 6'h02, // PCI/ISA I/O space
      REG_MEMCTL = 6'h04,    // Memory controller registers
      REG_HOSTBR = 6'h08,    // Host bridge registers
      REG_FLASH = 6'h10,     // Boot flash window
      REG_CUSTOM = 6'h20     // Software map in force
   } region_t;

   // Window bounds of the default map
   localparam logic [31:0] PCIISA_IO_BASE = 32'h8000_0000;
   localparam logic [31:0] PCIISA_IO_LAST = 32'h8001_ffff;
   localparam logic [31:0] MEMCTL_BASE = 32'hfef8_0000;
   localparam logic [31:0] MEMCTL_LAST = 32'hfef8_ffff;
   localparam logic [31:0] HOSTBR_BASE = 32'hfeff_0000;
   localparam logic [31:0] HOSTBR_LAST = 32'hfeff_ffff;
   localparam logic [31:0] FLASH_BASE = 32'hfff0_0000;
   localparam logic [31:0] FLASH_LAST = 32'hffff_ffff;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam src_t SRC_RESET = '0;
   // Local targets held in reset while the block itself is in reset
   localparam tgt_t TGT_RESET = 6'h3e;
   localparam logic PCI_DEC_EN_RESET = 1'b0;
   localparam logic MAP_CUSTOM_RESET = 1'b0;
   localparam region_t REGION_RESET = REG_UNMAPPED;
   localparam logic FLASH_SOCK_RESET = 1'b0;

endpackage

`default_nettype wire

/* File: design/board_reset_distribution.sv */
/*
 * Board reset distribution: synchronises the board's reset sources,
 * forms one reset per target, drives the VMEbus reset as system
 * controller, and keeps the reset-time address map state.
 * Assumes all source pins are asynchronous to mclk_in; decode address
 * and reprogram strobes come from logic on mclk_in.
 */
// How it works
// - Eight reset sources sampled independently.
// - Power-on resets locals, never the VMEbus.
// - Switch resets locals, VMEbus as controller.
// - Watchdog resets locals, VMEbus as controller.
// - Hot reset resets locals, VMEbus as controller.
// - PCI/ISA reset hits only PCI, ISA.
// - System soft reset adds VMEbus as controller; local does not.
// - System reset disables PCI decoders until reprogrammed.
// - Reset restores default processor map until reprogrammed.
// - Top flash window follows the bank swap bit.
`timescale 1ns/100ps
`default_nettype none

module board_reset_distribution
   import board_reset_pkg::*;
(
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic por_in,
   input wire logic reset_switch_in,
   input wire logic wdog_reset_in,
   input wire logic alternate_hot_reset_in,
   input wire logic pciisa_reset_in,
   input wire logic vme_sysreset_n_in,
   input wire logic vme_sys_sw_reset_in,
   input wire logic vme_local_sw_reset_in,
   input wire logic sys_ctrl_in,
   input wire logic flash_bank_swap_bit_in,
   input wire logic [31:0] cpu_addr_in,
   input wire logic map_reprog_in,
   input wire logic pci_dec_reprog_in,
   output logic proc_rst_out,
   output logic hostbr_rst_out,
   output logic memctl_rst_out,
   output logic pci_rst_out,
   output logic isa_rst_out,
   output logic vme_sysreset_out,
   output logic vme_sysreset_oe_out,
   output logic pci_dec_en_out,
   output logic map_default_out,
   output board_reset_pkg::region_t region_out,
   output logic flash_sock_out
);
   import board_reset_pkg::*;

   // -----------------------------------------------------------------
   // Types and functions
   // -----------------------------------------------------------------
   // Whole state of the block
   typedef struct packed {
      src_t sync1;        // First synchroniser stage
      src_t sync2;        // Second synchroniser stage
      logic sysctl1;      // Controller strap, first stage
      logic sysctl2;      // Controller strap, second stage
      tgt_t tgt;          // Registered target resets
      logic pci_dec_en;   // PCI decoders enabled
      logic map_custom;   // Software processor map in force
      region_t region;    // Decoded region of cpu_addr_in
      logic flash_sock;   // Flash window on socketed bank
   } state_t;

   // Sources that reset every local target
   function automatic logic local_reset(input src_t s);
      local_reset = s.por | s.sw | s.wdog | s.hot | s.vmein | s.vsys | s.vloc;
   endfunction

   // Map every source onto every target
   function automatic tgt_t target_map(input src_t s, input logic sysctl);
      tgt_t t;
      logic loc;
      loc = local_reset(s);
      t.proc = loc;
      t.hostbr = loc;
      t.memctl = loc;
      t.pci = loc | s.pciisa;
      t.isa = loc | s.pciisa;
      // Power-on and local soft reset never reach the VMEbus
      t.vme = sysctl & (s.sw | s.wdog | s.hot | s.vsys);
      target_map = t;
   endfunction

   // Default processor map decode
   function automatic region_t decode_default(input logic [31:0] a);
      region_t r;
      r = REG_UNMAPPED;
      if ((a >= PCIISA_IO_BASE) && (a <= PCIISA_IO_LAST))
      begin
         r = REG_PCIISA_IO;
      end
      else if ((a >= MEMCTL_BASE) && (a <= MEMCTL_LAST))
      begin
         r = REG_MEMCTL;
      end
      else if ((a >= HOSTBR_BASE) && (a <= HOSTBR_LAST))
      begin
         r = REG_HOSTBR;
      end
      else if (a >= FLASH_BASE)
      begin
         r = REG_FLASH;  // Window runs up to FLASH_LAST
      end
      decode_default = r;
   endfunction

   // -----------------------------------------------------------------
   // State registers
   // -----------------------------------------------------------------
   state_t st_q;   // Current state
   state_t st_d;   // Next state
   src_t raw;      // Source pins, active high
   tgt_t tgt_now;  // Targets from synchronised sources
   logic sys_rst;  // Any reset of the host bridge level

   // Gather pins, incoming VMEbus reset is active low
   always_comb
   begin
      raw.por = por_in;
      raw.sw = reset_switch_in;
      raw.wdog = wdog_reset_in;
      raw.hot = alternate_hot_reset_in;
      raw.pciisa = pciisa_reset_in;
      raw.vmein = ~vme_sysreset_n_in;
      raw.vsys = vme_sys_sw_reset_in;
      raw.vloc = vme_local_sw_reset_in;
   end

   // Targets and system reset from the second stage only
   always_comb
   begin
      tgt_now = target_map(st_q.sync2, st_q.sysctl2);
      sys_rst = tgt_now.hostbr;
   end

   // Next state
   always_comb
   begin
      st_d = st_q;
      // Two-stage synchronisers, first stage read only by the second
      st_d.sync1 = raw;
      st_d.sync2 = st_q.sync1;
      st_d.sysctl1 = sys_ctrl_in;
      st_d.sysctl2 = st_q.sysctl1;
      // Target resets follow their sources while any stays high
      st_d.tgt = tgt_now;
      // PCI decoders: reset wins over a reprogram strobe
      if (sys_rst)
      begin
         st_d.pci_dec_en = 1'b0;
      end
      else if (pci_dec_reprog_in)
      begin
         st_d.pci_dec_en = 1'b1;
      end
      // Processor map: default until software reprograms
      if (sys_rst)
      begin
         st_d.map_custom = 1'b0;
      end
      else if (map_reprog_in)
      begin
         st_d.map_custom = 1'b1;
      end
      // Region decode only while the default map rules
      if (st_q.map_custom)
      begin
         st_d.region = REG_CUSTOM;
      end
      else
      begin
         st_d.region = decode_default(cpu_addr_in);
      end
      // Socketed bank when the swap bit is set
      st_d.flash_sock = flash_bank_swap_bit_in;
   end

   // Register the state, frozen while the clock enable is low unless the block reset is low
   always_ff @(posedge mclk_in)
   begin
      if (!resetn_in)
      begin
         st_q.sync1 <= SRC_RESET;
         st_q.sync2 <= SRC_RESET;
         st_q.sysctl1 <= 1'b0;
         st_q.sysctl2 <= 1'b0;
         st_q.tgt <= TGT_RESET;
         st_q.pci_dec_en <= PCI_DEC_EN_RESET;
         st_q.map_custom <= MAP_CUSTOM_RESET;
         st_q.region <= REGION_RESET;
         st_q.flash_sock <= FLASH_SOCK_RESET;
      end
      else if (ce_in)
      begin
         st_q <= st_d;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // All from registers; VMEbus reset is open drain, drives low only
   assign proc_rst_out = st_q.tgt.proc;
   assign hostbr_rst_out = st_q.tgt.hostbr;
   assign memctl_rst_out = st_q.tgt.memctl;
   assign pci_rst_out = st_q.tgt.pci;
   assign isa_rst_out = st_q.tgt.isa;
   assign vme_sysreset_out = 1'b0;
   assign vme_sysreset_oe_out = st_q.tgt.vme;
   assign pci_dec_en_out = st_q.pci_dec_en;
   assign map_default_out = ~st_q.map_custom;
   assign region_out = st_q.region;
   assign flash_sock_out = st_q.flash_sock;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);

   // Pin reaches the second stage after two enabled edges
   a_sync_two_stage: assert property (
      (ce_in && raw.wdog) ##1 (ce_in && raw.wdog) |=> st_q.sync2.wdog)
      else $error("source not synchronised in two stages");

   // Power-on alone resets processor, never the VMEbus
   a_por_targets: assert property (
      ce_in && (st_q.sync2 == 8'h80) |=> proc_rst_out && isa_rst_out
         && !vme_sysreset_oe_out)
      else $error("power-on reset targets wrong");

   // Switch drives VMEbus only as controller
   a_switch_vme: assert property (
      ce_in && st_q.sync2.sw |=> vme_sysreset_oe_out == $past(st_q.sysctl2)
         && memctl_rst_out)
      else $error("switch reset targets wrong");

   // Watchdog resets locals and VMEbus as controller
   a_wdog_vme: assert property (
      ce_in && st_q.sync2.wdog && st_q.sysctl2 |=> vme_sysreset_oe_out
         && hostbr_rst_out)
      else $error("watchdog reset targets wrong");

   // Hot reset resets locals and VMEbus as controller
   a_hot_reset: assert property (
      ce_in && st_q.sync2.hot && st_q.sysctl2 |=> vme_sysreset_oe_out
         && proc_rst_out)
      else $error("hot reset targets wrong");

   // PCI/ISA reset alone leaves the processor side running
   a_pciisa_only: assert property (
      ce_in && (st_q.sync2 == 8'h08) |=> pci_rst_out && isa_rst_out
         && !proc_rst_out && !hostbr_rst_out && !memctl_rst_out)
      else $error("PCI/ISA reset reached processor side");

   // Incoming VMEbus reset resets every local target
   a_vme_in_local: assert property (
      ce_in && st_q.sync2.vmein |=> proc_rst_out && hostbr_rst_out
         && memctl_rst_out && pci_rst_out && isa_rst_out)
      else $error("incoming VMEbus reset missed a target");

   // Local soft reset alone never drives the VMEbus
   a_local_sw_no_vme: assert property (
      ce_in && (st_q.sync2 == 8'h01) |=> proc_rst_out && !vme_sysreset_oe_out)
      else $error("local soft reset drove VMEbus");

   // Decoders stay off until a strobe outside reset
   a_pci_dec_off: assert property (
      ce_in && sys_rst ##1 (!pci_dec_reprog_in || !ce_in) |=> !pci_dec_en_out)
      else $error("PCI decoders on without reprogram");

   // Reset brings back the default map and its decode; the decode
   // needs one more enabled edge, so a frozen clock is left out
   a_default_map: assert property (
      ce_in && sys_rst ##1 ce_in |-> map_default_out ##1 (region_out != REG_CUSTOM))
      else $error("default map not restored");

   // Flash window follows the swap bit
   a_flash_bank: assert property (
      ce_in |=> flash_sock_out == $past(flash_bank_swap_bit_in))
      else $error("flash bank select wrong");

   // Targets release once every source is gone
   a_release: assert property (
      ce_in && (st_q.sync2 == 8'h00) |=> !proc_rst_out && !pci_rst_out
         && !vme_sysreset_oe_out)
      else $error("target reset held without source");

   // Main scenarios
   c_vme_driven: cover property (ce_in && st_q.sync2.sw ##1 vme_sysreset_oe_out);
   c_pciisa_alone: cover property (pci_rst_out && !proc_rst_out);
   c_map_reprog: cover property (map_default_out ##1 !map_default_out);
   c_dec_enable: cover property (!pci_dec_en_out ##1 pci_dec_en_out);

endmodule

`default_nettype wire

/* File: dv/boot_sw_model.sv */
/*
 * Partner model: boot software that rewrites the map decoders after
 * a kick, promptly or after a lag, as one-cycle strobes.
 * Assumes the block's clock; kick and lag come from the bench.
 */
`timescale 1ns/100ps
`default_nettype none

module boot_sw_model
(
   input wire logic mclk_in,
   input wire logic kick_in,
   input wire logic pick_pci_in,
   input wire logic [3:0] lag_in,
   output var logic map_reprog_out,
   output var logic pci_dec_reprog_out
);
   logic [3:0] cnt_q = 4'h0; // Cycles left before the strobe
   logic pci_q = 1'b0; // Which decoder is rewritten

   // ----------------------------------------------------------
   // Strobe timer
   // ----------------------------------------------------------
   always_ff @(posedge mclk_in)
   begin
      if (kick_in)
      begin
         cnt_q <= lag_in;
         pci_q <= pick_pci_in;
      end
      else if (cnt_q != 4'h0)
         cnt_q <= cnt_q - 4'h1;
   end

   // One strobe cycle as the timer reaches one
   assign map_reprog_out = (cnt_q == 4'h1) && !pci_q;
   assign pci_dec_reprog_out = (cnt_q == 4'h1) && pci_q;
endmodule

`default_nettype wire

/* File: dv/board_reset_distribution_bench.sv */
/*
 * Self-checking bench: drives every reset source, compares the
 * target resets with a reference function, then exercises the
 * decoder enables and the default map decode.
 * Assumes the design package and the boot software partner model.
 */
`timescale 1ns/100ps
`default_nettype none

module board_reset_distribution_bench;
   import board_reset_pkg::*;
   logic mclk_in = 1'b0;
   logic resetn, ce, sysctl, swap, kick, pick;
   logic [3:0] lag;
   logic [31:0] addr;
   src_t s; // Source levels, active high
   logic proc, hostbr, memctl, pci, isa, voe, vdat, pdec, mdef, fsock, mstb, pstb;
   region_t region;
   tgt_t got; // Target outputs gathered
   int fails = 0;
   int cmp_count = 0;
   logic [31:0] rnd = 32'h178f2;
   logic [31:0] ad [11] = '{32'h0, 32'h8000_0000, 32'h8001_ffff, 32'h8002_0000,
      32'hfef8_0000, 32'hfef8_ffff, 32'hfef9_0000, 32'hfeff_0000, 32'hffef_ffff,
      32'hfff0_0000, 32'hffff_ffff};
   logic [5:0] rg [11] = '{6'h01, 6'h02, 6'h02, 6'h01, 6'h04, 6'h04, 6'h01, 6'h08,
      6'h01, 6'h10, 6'h10};

   // ----------------------------------------------------------
   // Clock, design and partner
   // ----------------------------------------------------------
   always #5 mclk_in = ~mclk_in;
   assign got = {proc, hostbr, memctl, pci, isa, voe};

   board_reset_distribution board_reset_distribution_inst (.mclk_in(mclk_in),
      .resetn_in(resetn), .ce_in(ce), .por_in(s.por), .reset_switch_in(s.sw),
      .wdog_reset_in(s.wdog), .alternate_hot_reset_in(s.hot),
      .pciisa_reset_in(s.pciisa), .vme_sysreset_n_in(~s.vmein),
      .vme_sys_sw_reset_in(s.vsys), .vme_local_sw_reset_in(s.vloc),
      .sys_ctrl_in(sysctl), .flash_bank_swap_bit_in(swap), .cpu_addr_in(addr),
      .map_reprog_in(mstb), .pci_dec_reprog_in(pstb), .proc_rst_out(proc),
      .hostbr_rst_out(hostbr), .memctl_rst_out(memctl), .pci_rst_out(pci),
      .isa_rst_out(isa), .vme_sysreset_out(vdat), .vme_sysreset_oe_out(voe),
      .pci_dec_en_out(pdec), .map_default_out(mdef), .region_out(region),
      .flash_sock_out(fsock));

   boot_sw_model boot_sw_model_inst (.mclk_in(mclk_in), .kick_in(kick),
      .pick_pci_in(pick), .lag_in(lag), .map_reprog_out(mstb),
      .pci_dec_reprog_out(pstb));

   // ----------------------------------------------------------
   // Reference model and helpers
   // ----------------------------------------------------------
   // Expected targets for steady source levels
   function automatic tgt_t exp_tgt(input src_t v, input logic sc);
      int loc;
      loc = v.por | v.sw | v.wdog | v.hot | v.vmein | v.vsys | v.vloc;
      return {loc[0], loc[0], loc[0], loc[0] | v.pciisa, loc[0] | v.pciisa,
         sc & (v.sw | v.wdog | v.hot | v.vsys)};
   endfunction

   // Next pseudo-random value
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // Count and report one comparison
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Let n edges pass, then settle
   task automatic step(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask

   // Hold sources steady long enough, then compare targets
   task automatic hold(input src_t v, input logic sc);
      s = v;
      sysctl = sc;
      step(5);
      chk(got, exp_tgt(v, sc));
      chk(vdat, 1'b0);
   endtask

   // Let the partner strobe one decoder after a lag
   task automatic rewrite(input logic p, input logic [3:0] l);
      kick = 1'b1;
      pick = p;
      lag = l;
      step(1);
      kick = 1'b0;
      step(int'(l) + 2);
   endtask

   // Counts, verdict and end of run
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge mclk_in);
      fails++;
      end_of_test();
   end

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial
   begin
      resetn = 1'b0;
      ce = 1'b1;
      s = SRC_RESET;
      sysctl = 1'b1;
      {swap, kick, pick} = 3'h0;
      lag = 4'h1;
      addr = 32'h0;
      step(3);
      chk(got, TGT_RESET);
      chk({pdec, mdef}, 2'h1);
      resetn = 1'b1;
      step(5);
      chk(got, 6'h00);
      $display("Reset test done");
      // Exact latency on assertion and release of the switch
      s.sw = 1'b1;
      step(2);
      chk(proc, 1'b0);
      step(1);
      chk(got, 6'h3f);
      s.sw = 1'b0;
      step(2);
      chk(proc, 1'b1);
      step(1);
      chk(got, 6'h00);
      $display("Latency test done");
      // Clock enable low freezes every register, then work resumes
      ce = 1'b0;
      s.wdog = 1'b1;
      step(5);
      chk(got, 6'h00);
      ce = 1'b1;
      step(3);
      chk(got, 6'h3f);
      s.wdog = 1'b0;
      step(3);
      chk(got, 6'h00);
      $display("Clock enable test done");
      // Each source alone, with and without controller role
      for (int i = 0; i < 16; i++)
      begin
         hold(src_t'(8'h80 >> (i / 2)), i[0]);
         hold(SRC_RESET, i[0]);
      end
      $display("Source table test done");
      // Overlapping random sources
      for (int i = 0; i < 40; i++)
      begin
         rnd = lfsr(rnd);
         addr = rnd;
         hold(src_t'(rnd[7:0] & rnd[15:8] & rnd[23:16]), rnd[24]);
      end
      hold(SRC_RESET, 1'b0);
      $display("Random test done");
      // Decoder enables around resets
      rewrite(1'b1, 4'h1);
      chk(pdec, 1'b1);
      rewrite(1'b0, 4'h5);
      chk({mdef, region}, {1'b0, REG_CUSTOM});
      hold(src_t'(8'h08), 1'b0);
      chk({pdec, mdef}, 2'h2);
      s = src_t'(8'h01);
      step(4);
      chk({pdec, mdef}, 2'h1);
      rewrite(1'b1, 4'h1);
      chk(pdec, 1'b0);
      s = SRC_RESET;
      step(5);
      chk(pdec, 1'b0);
      $display("Decoder test done");
      // Default map decode with the bank swap bit
      for (int i = 0; i < 11; i++)
      begin
         addr = ad[i];
         swap = i[1];
         step(1);
         chk(region, rg[i]);
         if (rg[i] == 6'h10)
            chk(fsock, swap);
      end
      $display("Map test done");
      end_of_test();
   end
endmodule

`default_nettype wire
